// *** sim/pet_pin_model.sv ***
// output pin model: resolves pad levels from the timer's data and enables
`timescale 1ns/1ps
`default_nettype none
module pet_pin_model (
  input  wire logic [31:0] drv_o,
  input  wire logic [31:0] drv_oe,
  output logic [31:0]      pad
);
  // undriven pads float up to the board pull-up, which open drain relies on
  assign pad = (drv_o & drv_oe) | ~drv_oe;
endmodule
`default_nettype wire

// *** sim/pet_top_properties.sv ***
// concurrent checks on the pin event timer ports
`timescale 1ns/1ps
`default_nettype none
`include "pet_consts.svh"
module pet_top_chk (
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire pet_pkg::pet_req_s req,
  input wire logic [31:0]       rdata,
  input wire logic [7:0]        sibling_start,
  input wire logic              seq_start,
  input wire logic [31:0]       general_output_port_o,
  input wire logic [31:0]       general_output_port_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire cfg_wr = req.wr && req.addr == `PET_OFS_OUTCFG;
  wire cmd_wr = req.wr && req.addr == `PET_OFS_CMD;
  a_rdata_idle_zero: assert property (!req.rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_state_upper_zero: assert property (req.rd && req.addr == `PET_OFS_STATE |=> rdata[31:1] == 31'h0)
    else $error("state read carries stray bits");
  a_oe_single_pin: assert property ($onehot0(general_output_port_oe))
    else $error("more than one pin enabled");
  a_o_only_driven: assert property ((general_output_port_o & ~general_output_port_oe) == 32'h0)
    else $error("data on a pin that is not driven");
  a_pin_select_now: assert property (cfg_wr && !req.wdata[0]
    |=> ##1 general_output_port_oe == (32'h1 << $past(req.wdata[8:4], 2)))
    else $error("pin select not applied at once");
  a_od_low_drive: assert property (cfg_wr && req.wdata[0] |=> ##1 general_output_port_o == 32'h0)
    else $error("open drain pin driven high");
  a_start_cause: assert property (seq_start |-> (cmd_wr && req.wdata[0]) || (|sibling_start))
    else $error("sequence began without a start");
  a_start_single: assert property (seq_start |=> !seq_start)
    else $error("start pulse longer than one cycle");
  a_stop_holds: assert property (cmd_wr && req.wdata[2:0] == 3'h2
    |=> ##2 $stable(general_output_port_o)[*3])
    else $error("pin moved after stop");
endmodule
bind pet_top pet_top_chk u_pet_top_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .req(req),
  .rdata(rdata),
  .sibling_start(sibling_start),
  .seq_start(seq_start),
  .general_output_port_o(general_output_port_o),
  .general_output_port_oe(general_output_port_oe)
);
`default_nettype wire

// *** sim/tb_pet_top.sv ***
// self-checking bench of the pin event timer
`timescale 1ns/1ps
`default_nettype none
`include "pet_consts.svh"
module tb_pet_top;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  pet_pkg::pet_req_s req = '0;
  logic [7:0]        sibling_start = 8'h0;
  logic [31:0]       rdata, po, poe, pad;
  logic              seq_start, lv;
  int                error_cnt = 0, checks_done = 0, cyc = 0, seed = 7184, p, s, a, t0;
  logic [31:0]       md [6] = '{32'h1, 32'h1, 32'h3, 32'h5, 32'h1, 32'h0};
  logic [31:0]       wv [6] = '{32'h5, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h0, 32'h5};
  logic [31:0]       ev [6] = '{`PET_US_MIN, `PET_US_MAX, `PET_MS_MAX, `PET_S_MAX, 32'h0, `PET_US_MIN};
  always #2.5 sys_clk = ~sys_clk;
  pet_top u_pet_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
    .sibling_start(sibling_start), .seq_start(seq_start), .general_output_port_o(po),
    .general_output_port_oe(poe));
  pet_pin_model u_pet_pin_model (.drv_o(po), .drv_oe(poe), .pad(pad));
  task end_sim;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // a hung wait lands here instead of running forever
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t: run timed out", $time);
      end_sim;
    end
  end
  function automatic int rnd(int m);
    return $unsigned($random(seed)) % m;
  endfunction
  // cycles that n microseconds take at the bench clock
  function automatic int us_cyc(int n);
    return n * `PET_US_CYC;
  endfunction
  task chk_val(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: value %h, expected %h", $time, g, e);
    end
  endtask
  task chk_pin(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: level %b, expected %b", $time, g, e);
    end
  endtask
  task chk_time(input int g, input int e);
    checks_done++;
    if (g < e - 8 || g > e + 8) begin
      error_cnt++;
      $display("ERROR %0t: event at %0d cycles, expected %0d", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  // write, then let the registered pin follow
  task wrs(input logic [7:0] ad, input logic [31:0] d);
    wr(ad, d);
    @(posedge sys_clk);
    #1;
  endtask
  task rdc(input logic [7:0] ad, input logic [31:0] e);
    @(posedge sys_clk);
    req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    chk_val(rdata, e);
  endtask
  task start;
    wr(`PET_OFS_CMD, 32'h1);
    t0 = cyc;
  endtask
  // wait for the selected pin to move, then time it from the start
  task flip_at(input int e, input logic nl);
    lv = pad[p];
    while (pad[p] === lv) begin
      @(posedge sys_clk);
      #1;
    end
    chk_time(cyc - t0, us_cyc(e));
    chk_pin(pad[p], nl);
  endtask
  task sib(input int k, input logic e);
    @(posedge sys_clk);
    sibling_start <= 8'h1 << k;
    #1;
    chk_pin(seq_start, e);
    @(posedge sys_clk);
    sibling_start <= 8'h0;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_pin(poe[0], 1'b1);
    chk_val(po, 32'h0);
    rdc(`PET_OFS_TRIG, 32'h0);
    rdc(`PET_OFS_REPC, 32'h0);
    rdc(`PET_OFS_STATE, 32'h0);
    rdc(8'h80, 32'h0);
    wr(`PET_OFS_NUM, 32'h9);
    rdc(`PET_OFS_NUM, 32'h8);
    wr(`PET_OFS_NUM, 32'h0);
    rdc(`PET_OFS_NUM, 32'h1);
    wr(`PET_OFS_REPC, 32'hffffffff);
    rdc(`PET_OFS_REPC, `PET_REPC_MAX);
    for (int i = 0; i < 6; i++) begin
      wr(`PET_OFS_MODE, md[i]);
      rdc(`PET_OFS_MODE, md[i]);
      wr(`PET_OFS_IV0, wv[i]);
      rdc(`PET_OFS_IV0, ev[i]);
    end
    $display("test defaults and limits done");
    p = rnd(32);
    wrs(`PET_OFS_OUTCFG, 32'(p) << 4);
    chk_pin(poe[p], 1'b1);
    wrs(`PET_OFS_LEVEL, 32'h1);
    chk_pin(pad[p], 1'b1);
    wrs(`PET_OFS_OUTCFG, (32'(p) << 4) | 32'h1);
    chk_pin(poe[p], 1'b0);
    wrs(`PET_OFS_LEVEL, 32'h0);
    chk_pin(pad[p], 1'b0);
    wrs(`PET_OFS_OUTCFG, 32'(p) << 4);
    $display("test output config done");
    a = 10 + rnd(4);
    wr(`PET_OFS_MODE, 32'h0);
    wr(`PET_OFS_NUM, 32'h2);
    wr(`PET_OFS_IV0, 32'(a));
    wr(`PET_OFS_IV0 + 8'h4, 32'd20);
    wr(`PET_OFS_DELAY, 32'd10);
    rdc(`PET_OFS_DELAY, 32'd10);
    wr(`PET_OFS_REPC, 32'h3);
    start();
    flip_at(10 + a, 1'b1);
    rdc(`PET_OFS_REM, 32'h2);
    rdc(`PET_OFS_STATE, 32'h1);
    flip_at(30 + a, 1'b0);
    flip_at(30 + 2 * a, 1'b1);
    rdc(`PET_OFS_STATE, 32'h0);
    rdc(`PET_OFS_REM, 32'h0);
    $display("test toggle done");
    wr(`PET_OFS_LEVEL, 32'h0);
    wrs(`PET_OFS_OUTCFG, (32'(p) << 4) | 32'h2);
    chk_pin(pad[p], 1'b1);
    wr(`PET_OFS_MODE, 32'h1);
    wr(`PET_OFS_IV0, 32'd10);
    wr(`PET_OFS_IV0 + 8'h4, 32'd10);
    wr(`PET_OFS_DELAY, 32'h0);
    wr(`PET_OFS_REPC, 32'h1);
    start();
    flip_at(10, 1'b0);
    flip_at(20, 1'b1);
    rdc(`PET_OFS_STATE, 32'h0);
    wrs(`PET_OFS_OUTCFG, 32'(p) << 4);
    chk_pin(pad[p], 1'b0);
    $display("test pulse done");
    s = rnd(8);
    wr(`PET_OFS_TRIG, 32'h8 | 32'(s));
    rdc(`PET_OFS_TRIG, 32'h8 | 32'(s));
    wr(`PET_OFS_MODE, 32'h1);
    wr(`PET_OFS_NUM, 32'h1);
    start();
    rdc(`PET_OFS_STATE, 32'h1);
    repeat (300) @(posedge sys_clk);
    #1;
    chk_pin(pad[p], 1'b0);
    sib((s + 1) % 8, 1'b0);
    sib(s, 1'b1);
    t0 = cyc;
    flip_at(10, 1'b1);
    flip_at(20, 1'b0);
    $display("test trigger done");
    wr(`PET_OFS_TRIG, 32'h0);
    wr(`PET_OFS_REPC, 32'h0);
    wr(`PET_OFS_MODE, 32'h0);
    wr(`PET_OFS_LEVEL, 32'h1);
    start();
    repeat (100) @(posedge sys_clk);
    rdc(`PET_OFS_REM, `PET_REPC_MAX);
    wr(`PET_OFS_CMD, 32'h2);
    rdc(`PET_OFS_STATE, 32'h0);
    rdc(`PET_OFS_REM, 32'h0);
    repeat (2500) @(posedge sys_clk);
    #1;
    chk_pin(pad[p], 1'b1);
    rdc(`PET_OFS_LEVEL, 32'h1);
    wr(`PET_OFS_CMD, 32'h4);
    rdc(`PET_OFS_OUTCFG, 32'h0);
    rdc(`PET_OFS_NUM, 32'h1);
    rdc(`PET_OFS_LEVEL, 32'h0);
    $display("test stop and reset done");
    end_sim;
  end
endmodule
`default_nettype wire

// *** verilog/pet_consts.svh ***
// constants for the pin event timer: offsets, fields, limits, timing
`ifndef PET_CONSTS_SVH
`define PET_CONSTS_SVH

// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define PET_ADDR_W      8
`define PET_OFS_CMD     8'h00
`define PET_OFS_MODE    8'h04
`define PET_OFS_OUTCFG  8'h08
`define PET_OFS_TRIG    8'h0c
`define PET_OFS_DELAY   8'h10
`define PET_OFS_REPC    8'h14
`define PET_OFS_NUM     8'h18
`define PET_OFS_LEVEL   8'h1c
`define PET_OFS_IV0     8'h20
`define PET_OFS_STATE   8'h40
`define PET_OFS_REM     8'h44

// -----------------------------------------------------------------------------
// fields
// -----------------------------------------------------------------------------
`define PET_CMD_START   0
`define PET_CMD_STOP    1
`define PET_CMD_RESET   2
`define PET_MODE_PULSE  0
`define PET_MODE_UNIT   2:1
`define PET_OUT_OD      0
`define PET_OUT_INV     1
`define PET_OUT_PIN     8:4
`define PET_TRIG_EN     3
`define PET_TRIG_SRC    2:0

// -----------------------------------------------------------------------------
// limits and timing
// -----------------------------------------------------------------------------
`define PET_REPC_MAX    30'h3b9aca00
`define PET_NUM_MAX     4'h8
`define PET_US_MIN      32'h0000000a
`define PET_US_MAX      32'h6b49d200
`define PET_MS_MAX      32'h001b7740
`define PET_S_MAX       32'h00000708
`define PET_CLK_PS      5000
`define PET_US_PS       1000000
`define PET_US_CYC      (`PET_US_PS / `PET_CLK_PS)
`define PET_PER_UNIT    1000

`endif

// *** verilog/pet_pkg.sv ***
// types shared by the pin event timer
`default_nettype none
package pet_pkg;

  typedef enum logic [1:0] {
    PET_UNIT_US,
    PET_UNIT_MS,
    PET_UNIT_S
  } pet_unit_e;

  typedef enum logic [1:0] {
    PET_IDLE,
    PET_PEND,
    PET_DELAY,
    PET_RUN
  } pet_state_e;

  typedef struct packed {
    logic      pulse;
    pet_unit_e unit;
    logic      od;
    logic      inv;
    logic [4:0] pin;
  } pet_cfg_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pet_req_s;

endpackage
`default_nettype wire

// *** verilog/pet_top.sv ***
// pin event timer: toggle and pulse output generator with register port
`timescale 1ns/1ps
`default_nettype none
`include "pet_consts.svh"

module pet_top (
  input  wire logic            sys_clk,
  input  wire logic            sys_rst,
  input  wire pet_pkg::pet_req_s req,
  output logic [31:0]          rdata,
  input  wire logic [7:0]      sibling_start,
  output logic                 seq_start,
  output logic [31:0]          general_output_port_o,
  output logic [31:0]          general_output_port_oe
);

  // ---------------------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------------------
  pet_pkg::pet_cfg_s   cfg_reg;
  logic                trig_en_reg;
  logic [2:0]          trig_src_reg;
  logic [31:0]         delay_reg;
  logic [29:0]         repc_reg;
  logic [3:0]          num_reg;
  logic [31:0]         iv_reg [0:7];
  logic                level_reg;
  pet_pkg::pet_state_e state_reg;
  logic [29:0]         rem_reg;
  logic [2:0]          idx_reg;
  logic                phase_reg;
  logic [31:0]         cnt_reg;
  logic [7:0]          us_cnt_reg;
  logic [9:0]          ms_cnt_reg;
  logic [9:0]          s_cnt_reg;

  logic wr_cmd;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_reset;
  logic wr_level;
  logic us_tick;
  logic ms_tick;
  logic s_tick;
  logic tick;
  logic ev;
  logic begin_seq;
  logic last_rep;
  logic [31:0] target;

  assign wr_cmd    = req.wr && (req.addr == `PET_OFS_CMD);
  assign cmd_start = wr_cmd && req.wdata[`PET_CMD_START];
  assign cmd_stop  = wr_cmd && req.wdata[`PET_CMD_STOP];
  assign cmd_reset = wr_cmd && req.wdata[`PET_CMD_RESET];
  assign wr_level  = req.wr && (req.addr == `PET_OFS_LEVEL);

  // interval limits follow the unit selected when the value is written
  function automatic logic [31:0] clamp_iv(input logic [31:0] v, input pet_pkg::pet_cfg_s c);
    logic [31:0] r;
    r = v;
    case (c.unit)
      pet_pkg::PET_UNIT_US: begin
        if (v > `PET_US_MAX) begin
          r = `PET_US_MAX;
        end else if ((v < `PET_US_MIN) && (v != 32'h0 || !c.pulse)) begin
          r = `PET_US_MIN;
        end
      end
      pet_pkg::PET_UNIT_MS: begin
        if (v > `PET_MS_MAX) begin
          r = `PET_MS_MAX;
        end else if (v == 32'h0 && !c.pulse) begin
          r = 32'h1;
        end
      end
      default: begin
        if (v > `PET_S_MAX) begin
          r = `PET_S_MAX;
        end else if (v == 32'h0 && !c.pulse) begin
          r = 32'h1;
        end
      end
    endcase
    return r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmd_reset) begin
      cfg_reg <= '{pulse: 1'b0, unit: pet_pkg::PET_UNIT_US, od: 1'b0, inv: 1'b0, pin: 5'h00};
    end else if (req.wr && req.addr == `PET_OFS_MODE) begin
      cfg_reg.pulse <= req.wdata[`PET_MODE_PULSE];
      cfg_reg.unit  <= pet_pkg::pet_unit_e'(req.wdata[`PET_MODE_UNIT]);
    end else if (req.wr && req.addr == `PET_OFS_OUTCFG) begin
      cfg_reg.od  <= req.wdata[`PET_OUT_OD];
      cfg_reg.inv <= req.wdata[`PET_OUT_INV];
      cfg_reg.pin <= req.wdata[`PET_OUT_PIN];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmd_reset) begin
      trig_en_reg  <= 1'b0;
      trig_src_reg <= 3'h0;
    end else if (req.wr && req.addr == `PET_OFS_TRIG) begin
      trig_en_reg  <= req.wdata[`PET_TRIG_EN];
      trig_src_reg <= req.wdata[`PET_TRIG_SRC];
    end
  end

  // out-of-range counts are clamped, not refused, so a read shows what will run, except a repeat count of 0, which runs PET_REPC_MAX
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmd_reset) begin
      delay_reg <= 32'h0;
      repc_reg  <= 30'h0;
      num_reg   <= 4'h1;
    end else if (req.wr) begin
      if (req.addr == `PET_OFS_DELAY) begin
        delay_reg <= req.wdata;
      end else if (req.addr == `PET_OFS_REPC) begin
        if (req.wdata > 32'(`PET_REPC_MAX)) begin
          repc_reg <= `PET_REPC_MAX;
        end else begin
          repc_reg <= req.wdata[29:0];
        end
      end else if (req.addr == `PET_OFS_NUM) begin
        if (req.wdata == 32'h0) begin
          num_reg <= 4'h1;
        end else if (req.wdata > 32'(`PET_NUM_MAX)) begin
          num_reg <= `PET_NUM_MAX;
        end else begin
          num_reg <= req.wdata[3:0];
        end
      end
    end
  end

  // each interval keeps the limit of the unit in force when it was written;
  // a later unit change does not re-clamp values already stored
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (sys_rst || cmd_reset) begin
        iv_reg[i] <= 32'h0;
      end else if (req.wr && req.addr == 8'(`PET_OFS_IV0 + 4 * i)) begin
        iv_reg[i] <= clamp_iv(req.wdata, cfg_reg);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------------------
  // prescalers restart on every event so each interval is whole units long
  assign us_tick = (us_cnt_reg == 8'(`PET_US_CYC - 1));
  assign ms_tick = us_tick && (ms_cnt_reg == 10'(`PET_PER_UNIT - 1));
  assign s_tick  = ms_tick && (s_cnt_reg == 10'(`PET_PER_UNIT - 1));

  always_comb begin
    case (cfg_reg.unit)
      pet_pkg::PET_UNIT_MS: tick = ms_tick;
      pet_pkg::PET_UNIT_S:  tick = s_tick;
      default:              tick = us_tick;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_reg == pet_pkg::PET_IDLE || state_reg == pet_pkg::PET_PEND || ev) begin
      us_cnt_reg <= 8'h0;
      ms_cnt_reg <= 10'h0;
      s_cnt_reg  <= 10'h0;
    end else if (us_tick) begin
      us_cnt_reg <= 8'h0;
      if (ms_tick) begin
        ms_cnt_reg <= 10'h0;
        s_cnt_reg  <= s_tick ? 10'h0 : s_cnt_reg + 10'h1;
      end else begin
        ms_cnt_reg <= ms_cnt_reg + 10'h1;
      end
    end else begin
      us_cnt_reg <= us_cnt_reg + 8'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    if (state_reg == pet_pkg::PET_DELAY) begin
      target = delay_reg;
    end else if (cfg_reg.pulse) begin
      target = phase_reg ? iv_reg[1] : iv_reg[0];
    end else begin
      target = iv_reg[idx_reg];
    end
  end

  assign ev = (state_reg == pet_pkg::PET_DELAY || state_reg == pet_pkg::PET_RUN) && (cnt_reg >= target);
  assign last_rep = (rem_reg == 30'h1);
  // a triggered instance must already be pending when its source starts
  // a start while busy is ignored; only idle or pending can begin a run
  assign begin_seq = (state_reg == pet_pkg::PET_PEND && sibling_start[trig_src_reg]) ||
                     (state_reg == pet_pkg::PET_IDLE && cmd_start && !trig_en_reg);
  assign seq_start = begin_seq;

  // stop and reset win over a start seen in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmd_reset || cmd_stop) begin
      state_reg <= pet_pkg::PET_IDLE;
    end else begin
      case (state_reg)
        pet_pkg::PET_IDLE: begin
          if (cmd_start && trig_en_reg) begin
            state_reg <= pet_pkg::PET_PEND;
          end else if (begin_seq) begin
            state_reg <= pet_pkg::PET_DELAY;
          end
        end
        pet_pkg::PET_PEND: begin
          if (begin_seq) begin
            state_reg <= pet_pkg::PET_DELAY;
          end
        end
        pet_pkg::PET_DELAY: begin
          if (ev) begin
            state_reg <= pet_pkg::PET_RUN;
          end
        end
        default: begin
          if (ev && last_rep && (!cfg_reg.pulse || phase_reg)) begin
            state_reg <= pet_pkg::PET_IDLE;
          end
        end
      endcase
    end
  end

  // restarting on every event costs one extra cycle per event
  always_ff @(posedge sys_clk) begin
    if (sys_rst || begin_seq || ev) begin
      cnt_reg <= 32'h0;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // the remaining count drops only on finished repetitions, a stop or a reset, never on the event that ends the delay
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmd_reset) begin
      rem_reg   <= 30'h0;
      idx_reg   <= 3'h0;
      phase_reg <= 1'b0;
    end else if (cmd_stop) begin
      rem_reg <= 30'h0;
    end else if (begin_seq) begin
      rem_reg   <= (repc_reg == 30'h0) ? `PET_REPC_MAX : repc_reg;
      idx_reg   <= 3'h0;
      phase_reg <= 1'b0;
    end else if (ev && state_reg == pet_pkg::PET_RUN) begin
      if (cfg_reg.pulse) begin
        phase_reg <= !phase_reg;
        if (phase_reg) begin
          rem_reg <= rem_reg - 30'h1;
        end
      end else begin
        rem_reg <= rem_reg - 30'h1;
        if ({1'b0, idx_reg} == num_reg - 4'h1) begin
          idx_reg <= 3'h0;
        end else begin
          idx_reg <= idx_reg + 3'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // output level and pin drive
  // ---------------------------------------------------------------------------
  // a static level write wins over an event in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmd_reset) begin
      level_reg <= 1'b0;
    end else if (wr_level) begin
      level_reg <= req.wdata[0];
    end else if (begin_seq && cfg_reg.pulse) begin
      level_reg <= 1'b0;
    end else if (ev && state_reg == pet_pkg::PET_RUN) begin
      if (cfg_reg.pulse) begin
        level_reg <= !phase_reg;
      end else begin
        level_reg <= !level_reg;
      end
    end
  end

  // open drain only pulls low; the pin floats for a high level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      general_output_port_o  <= 32'h0;
      general_output_port_oe <= 32'h0;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (5'(i) == cfg_reg.pin) begin
          general_output_port_o[i]  <= cfg_reg.od ? 1'b0 : (level_reg ^ cfg_reg.inv);
          general_output_port_oe[i] <= cfg_reg.od ? !(level_reg ^ cfg_reg.inv) : 1'b1;
        end else begin
          general_output_port_o[i]  <= 1'b0;
          general_output_port_oe[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------------
  // unmapped and write-only offsets read as zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !req.rd) begin
      rdata <= 32'h0;
    end else if (req.addr == `PET_OFS_MODE) begin
      rdata <= {29'h0, cfg_reg.unit, cfg_reg.pulse};
    end else if (req.addr == `PET_OFS_OUTCFG) begin
      rdata <= {23'h0, cfg_reg.pin, 2'h0, cfg_reg.inv, cfg_reg.od};
    end else if (req.addr == `PET_OFS_TRIG) begin
      rdata <= {28'h0, trig_en_reg, trig_src_reg};
    end else if (req.addr == `PET_OFS_DELAY) begin
      rdata <= delay_reg;
    end else if (req.addr == `PET_OFS_REPC) begin
      rdata <= {2'h0, repc_reg};
    end else if (req.addr == `PET_OFS_NUM) begin
      rdata <= {28'h0, num_reg};
    end else if (req.addr == `PET_OFS_LEVEL) begin
      rdata <= {31'h0, level_reg};
    end else if (req.addr >= `PET_OFS_IV0 && req.addr < `PET_OFS_STATE && req.addr[1:0] == 2'h0) begin
      rdata <= iv_reg[req.addr[4:2]];
    end else if (req.addr == `PET_OFS_STATE) begin
      rdata <= {31'h0, state_reg != pet_pkg::PET_IDLE};
    end else if (req.addr == `PET_OFS_REM) begin
      rdata <= {2'h0, rem_reg};
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule
`default_nettype wire
